// ---- verilog/sst_top.sv ----
// Sequencer self-test engine: drives probes into the sequencer logic,
// samples the detectors, and builds the self-test status word.
// Detector inputs come from outside this clock and are synchronised.
`timescale 1ns/1ps
module sst_top
  import sst_pkg::*;
#(
  parameter int LIMIT_CYC = sst_pkg::WAIT_CYC
)(
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  output logic             reg_rd_ack,
  input  wire logic [4:0]  own_addr,
  input  wire logic        rx_addr_hit,
  input  wire logic        crc_err,
  input  wire logic [2:0]  cnt_carry,
  input  wire logic        sev_err,
  input  wire logic        par_err,
  input  wire logic        rf_err,
  input  wire logic        mod_reply,
  output logic      [4:0]  probe_addr,
  output logic             crc_inject,
  output logic             cnt_load,
  output logic             sev_bad,
  output logic             sev_run,
  output logic             par_bad,
  output logic             par_run,
  output logic             rf_run,
  output logic             rf_addr_mode,
  output logic      [3:0]  mod_addr,
  output logic             mod_xfer,
  output logic             mod_badchk,
  output logic             busy
);
  import sst_pkg::*;

  sst_state_t  state_q, state_d;     // Sequencer phase
  logic [4:0]  idx_q, idx_d;         // Address or module index
  logic [1:0]  sub_q, sub_d;         // Step within one index
  logic [3:0]  wt_q, wt_d;           // Settle counter
  logic [15:0] stat_q, stat_d;       // Self-test status word
  logic        mute_q, mute_d;       // Fatal: status read unanswered
  logic        ran_q, ran_d;         // A test ended since power-up
  logic        rep_q, rep_d;         // This run is a repeat
  logic [IN_W-1:0] s1_q, s2_q;       // Input synchroniser stages
  logic [15:0] rdata_q, rdata_d;
  logic        ack_q, ack_d;
  logic [4:0]  pa_q, pa_d;
  logic [3:0]  ma_q, ma_d;
  logic        crc_q, crc_d, cl_q, cl_d, sb_q, sb_d, sr_q, sr_d;
  logic        pb_q, pb_d, pr_q, pr_d, rr_q, rr_d, rm_q, rm_d;
  logic        mx_q, mx_d, mb_q, mb_d;
  logic        last, start;
  logic        busy_q, busy_d;       // Test running, kept in a flop

  // Outputs straight from flops
  assign reg_rdata    = rdata_q;
  assign reg_rd_ack   = ack_q;
  assign probe_addr   = pa_q;
  assign crc_inject   = crc_q;
  assign cnt_load     = cl_q;
  assign sev_bad      = sb_q;
  assign sev_run      = sr_q;
  assign par_bad      = pb_q;
  assign par_run      = pr_q;
  assign rf_run       = rr_q;
  assign rf_addr_mode = rm_q;
  assign mod_addr     = ma_q;
  assign mod_xfer     = mx_q;
  assign mod_badchk   = mb_q;
  assign busy         = busy_q;

  // Sample point: stimulus has settled and passed the synchroniser
  assign last  = (wt_q == 4'(SETTLE_CYC - 1));
  // Only a start command is accepted once idle or finished
  assign start = reg_wr && (reg_addr == OFF_CTRL) &&
                 reg_wdata[CTRL_START] && !busy;

  // Next state of sequencer, status word and register port
  always_comb
  begin
    state_d = state_q;
    idx_d   = idx_q;
    sub_d   = sub_q;
    wt_d    = last ? 4'h0 : wt_q + 4'h1;
    stat_d  = stat_q;
    mute_d  = mute_q;
    ran_d   = ran_q;
    rep_d   = rep_q;
    // Stimulus follows the current step; strobes idle by default, addresses and rf_addr_mode follow idx_q and sub_q
    pa_d  = idx_q;
    ma_d  = idx_q[3:0];
    crc_d = (state_q == S_CRC);
    cl_d  = (state_q == S_CNT);
    sr_d  = (state_q == S_SEV);
    sb_d  = (state_q == S_SEV) && sub_q[0];
    pr_d  = (state_q == S_PAR);
    pb_d  = (state_q == S_PAR) && !sub_q[0];
    rr_d  = (state_q == S_RF);
    rm_d  = sub_q[0];
    mx_d  = (state_q == S_BUS) && (sub_q != 2'd0);
    mb_d  = (state_q == S_BUS) && (sub_q == 2'd2);
    case (state_q)
      S_IDLE, S_DONE:
      begin
        wt_d = 4'h0;
        if (start)
        begin
          state_d = S_ADDR;
          idx_d   = 5'd0;
          sub_d   = 2'd0;
          stat_d  = STAT_RST;
          mute_d  = 1'b0;
          rep_d   = ran_q;
        end
      end
      S_ADDR:
        if (last)
        begin
          // Hit must come for own address only
          if (s2_q[IN_HIT] != (idx_q == s2_q[IN_OWN +: 5]))
          begin
            state_d = S_DONE;
            mute_d  = 1'b1;
          end
          else if (idx_q == 5'(ADDR_N - 1))
            state_d = S_CRC;
          idx_d = idx_q + 5'd1;
        end
      S_CRC:
        if (last)
        begin
          // A missed bad check is fatal
          if (!s2_q[IN_CRC])
          begin
            state_d = S_DONE;
            mute_d  = 1'b1;
          end
          else
            state_d = S_CNT;
        end
      S_CNT:
        if (last)
        begin
          // Counters loaded alike must roll over together
          if (s2_q[IN_CNT +: 3] != 3'b111)
          begin
            state_d = S_DONE;
            mute_d  = 1'b1;
          end
          else
          begin
            state_d = S_SEV;
            stat_d  = W_PROG_FATAL;
          end
        end
      S_SEV:
        if (last)
        begin
          // Step 0 good pattern, step 1 bad pattern
          if (!sub_q[0] && s2_q[IN_SEV])
          begin
            state_d = S_DONE;
            stat_d  = W_SEV_GOOD;
          end
          else if (sub_q[0] && !s2_q[IN_SEV])
          begin
            state_d = S_DONE;
            stat_d  = W_SEV_BAD;
          end
          else if (sub_q[0])
          begin
            state_d = S_PAR;
            stat_d  = W_PROG_SEV;
          end
          sub_d = sub_q[0] ? 2'd0 : 2'd1;
        end
      S_PAR:
        if (last)
        begin
          // Step 0 forced bad parity, step 1 good parity
          if (!sub_q[0] && !s2_q[IN_PAR])
          begin
            state_d = S_DONE;
            stat_d  = W_PAR_STUCK;
          end
          else if (sub_q[0] && s2_q[IN_PAR])
          begin
            state_d = S_DONE;
            stat_d  = W_PAR_TREE;
          end
          else if (sub_q[0])
          begin
            state_d = S_RF;
            stat_d  = W_PROG_PAR;
          end
          sub_d = sub_q[0] ? 2'd0 : 2'd1;
        end
      S_RF:
        if (last)
        begin
          // Data pattern pass, then address pattern pass
          if (s2_q[IN_RF])
          begin
            state_d = S_DONE;
            stat_d  = W_RF_FAIL;
          end
          else if (sub_q[0])
          begin
            state_d = S_BUS;
            idx_d   = 5'd0;
          end
          sub_d = sub_q[0] ? 2'd0 : 2'd1;
        end
      S_BUS:
        if (last)
        begin
          // Idle: no reply; good check: reply; bad check: none
          if ((sub_q != 2'd1) == s2_q[IN_REP])
          begin
            state_d = S_DONE;
            // Module address in field, field MSB (bit 12) left 0
            stat_d  = W_MOD_FAIL | {12'h000, idx_q[3:0]};
            if (rep_q && (sub_q != 2'd2))
              stat_d = stat_d & ~W_REPEAT_CLR;
          end
          else if (sub_q == 2'd2)
          begin
            sub_d = 2'd0;
            idx_d = idx_q + 5'd1;
            if (idx_q == 5'(MOD_N - 1))
            begin
              state_d = S_DONE;
              stat_d  = W_PASS;
            end
          end
          else
            sub_d = sub_q + 2'd1;
        end
      default:
        state_d = S_IDLE;
    endcase
    if (state_d == S_DONE)
      ran_d = 1'b1;
    // Register reads; fatal result leaves status read unanswered
    ack_d   = reg_rd && !(mute_q && reg_addr == OFF_STAT);
    rdata_d = 16'h0000;
    if (ack_d && reg_addr == OFF_CTRL)
      rdata_d[CTRL_BUSY] = busy;
    else if (ack_d && reg_addr == OFF_STAT)
      rdata_d = stat_q;
    // Busy follows the next phase so the pin comes from a flop
    busy_d = (state_d != S_IDLE) && (state_d != S_DONE);
  end

  // All state registers; only the second sync stage is read by the sequencer
  always_ff @(posedge clk_sys)
  begin
    s1_q <= {own_addr, mod_reply, rf_err, par_err, sev_err,
             cnt_carry, crc_err, rx_addr_hit};
    s2_q <= s1_q;
    if (!rst_b)
    begin
      state_q <= S_IDLE;
      idx_q   <= 5'd0;
      sub_q   <= 2'd0;
      wt_q    <= 4'h0;
      stat_q  <= STAT_RST;
      mute_q  <= 1'b0;
      ran_q   <= 1'b0;
      rep_q   <= 1'b0;
      rdata_q <= 16'h0000;
      ack_q   <= 1'b0;
      busy_q  <= 1'b0;
      {pa_q, ma_q} <= 9'h000;
      {crc_q, cl_q, sb_q, sr_q, pb_q, pr_q} <= 6'h00;
      {rr_q, rm_q, mx_q, mb_q} <= 4'h0;
    end
    else
    begin
      state_q <= state_d;
      idx_q   <= idx_d;
      sub_q   <= sub_d;
      wt_q    <= wt_d;
      stat_q  <= stat_d;
      mute_q  <= mute_d;
      ran_q   <= ran_d;
      rep_q   <= rep_d;
      rdata_q <= rdata_d;
      ack_q   <= ack_d;
      busy_q  <= busy_d;
      {pa_q, ma_q} <= {pa_d, ma_d};
      {crc_q, cl_q, sb_q, sr_q, pb_q, pr_q} <=
        {crc_d, cl_d, sb_d, sr_d, pb_d, pr_d};
      {rr_q, rm_q, mx_q, mb_q} <= {rr_d, rm_d, mx_d, mb_d};
    end
  end

  // Helper: cycles since start, for the host wait bound
  logic [31:0] run_q;
  always_ff @(posedge clk_sys)
    run_q <= (!rst_b || start) ? 32'd0 : run_q + {31'd0, busy};

  a_run_bound: assert property (@(posedge clk_sys) disable iff (!rst_b)
    busy |-> run_q < 32'(LIMIT_CYC))
    else $error("self test outlasts host wait");
  a_result_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state_q == S_DONE) && !start |=> $stable(stat_q))
    else $error("result changed after end");
  a_mute_read: assert property (@(posedge clk_sys) disable iff (!rst_b)
    mute_q && reg_rd && reg_addr == OFF_STAT |=> !reg_rd_ack)
    else $error("status answered after fatal fault");
  a_pass_word: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state_q == S_DONE) && stat_q[PASS_BIT] |-> stat_q == W_PASS)
    else $error("pass bit without pass word");
  a_addr_fatal: assert property (@(posedge clk_sys) disable iff (!rst_b)
    state_q == S_ADDR && last &&
    s2_q[IN_HIT] != (idx_q == s2_q[IN_OWN +: 5])
    |=> state_q == S_DONE && mute_q)
    else $error("address fault not fatal");
  a_sev_good: assert property (@(posedge clk_sys) disable iff (!rst_b)
    state_q == S_SEV && last && !sub_q[0] && s2_q[IN_SEV]
    |=> stat_q == W_SEV_GOOD && state_q == S_DONE)
    else $error("good pattern reject word wrong");
  a_par_stuck: assert property (@(posedge clk_sys) disable iff (!rst_b)
    state_q == S_PAR && last && !sub_q[0] && !s2_q[IN_PAR]
    |=> stat_q == W_PAR_STUCK && !stat_q[PASS_BIT])
    else $error("stuck parity word wrong");
  a_mod_addr: assert property (@(posedge clk_sys) disable iff (!rst_b)
    state_q == S_BUS && state_d == S_DONE && stat_d != W_PASS
    |=> stat_q[3:0] == $past(idx_q[3:0]) && !stat_q[4])
    else $error("module address not in field");
endmodule : sst_top

// ---- verilog/sst_pkg.sv ----
// Constants for the sequencer self-test engine: map, words, timing.
// Assumes a 25 MHz system clock and a plain strobe register port.
package sst_pkg;
  // Register offsets and control bits
  localparam logic [3:0] OFF_CTRL   = 4'h0;
  localparam logic [3:0] OFF_STAT   = 4'h4;
  localparam int         CTRL_START = 0;    // Write 1: run the test
  localparam int         CTRL_BUSY  = 0;    // Read: test running
  // Status word, doc bit n sits at data bit 16-n (bit 1 is the MSB)
  localparam logic [15:0] STAT_RST     = 16'h0000;
  localparam logic [15:0] W_PROG_FATAL = 16'h2D00; // 3,5,6,8
  localparam logic [15:0] W_PROG_SEV   = 16'h3D00; // 3,4,5,6,8
  localparam logic [15:0] W_PROG_PAR   = 16'h7DC0; // 2-6,8,9,10
  localparam logic [15:0] W_PAR_STUCK  = 16'h2D01;
  localparam logic [15:0] W_SEV_BAD    = 16'h3D01;
  localparam logic [15:0] W_SEV_GOOD   = 16'h3D81;
  localparam logic [15:0] W_PAR_TREE   = 16'h3D02;
  localparam logic [15:0] W_RF_FAIL    = 16'h7DC3;
  localparam logic [15:0] W_MOD_FAIL   = 16'h7DC0;
  localparam logic [15:0] W_PASS       = 16'h7F73;
  localparam logic [15:0] W_REPEAT_CLR = 16'h3000; // Bits 3 and 4
  localparam int          PASS_BIT     = 5;        // Doc bit 11
  // Sequencing
  localparam int ADDR_N     = 32;
  localparam int MOD_N      = 16;
  localparam int SETTLE_CYC = 8;  // Covers output flop, far logic, sync
  // Host wait before reading the result
  localparam int CLK_NS      = 40;
  localparam int WAIT_NS     = 1040000;
  localparam int WAIT_CYC    = WAIT_NS / CLK_NS;  // Longest: round down
  // Positions in the synchronised input vector
  localparam int IN_HIT = 0;
  localparam int IN_CRC = 1;
  localparam int IN_CNT = 2;   // Three bits
  localparam int IN_SEV = 5;
  localparam int IN_PAR = 6;
  localparam int IN_RF  = 7;
  localparam int IN_REP = 8;
  localparam int IN_OWN = 9;   // Five bits
  localparam int IN_W   = 14;
  typedef enum logic [3:0] {
    S_IDLE, S_ADDR, S_CRC, S_CNT, S_SEV, S_PAR, S_RF, S_BUS, S_DONE
  } sst_state_t;
endpackage : sst_pkg

// ---- verif/sst_far.sv ----
// Far-side model of the sequencer logic that the self-test probes.
// Assumes the engine holds each probe level for a whole step; answers
// are combinational, so they settle well before the engine samples.
`timescale 1ns/1ps
module sst_far
  import sst_pkg::*;
(
  input  wire logic [3:0] fault,        // 0 healthy, 1 to 9 injected fault
  input  wire logic [4:0] own_addr,     // Strapped unit address
  input  wire logic [4:0] probe_addr,   // Address under probe
  input  wire logic       crc_inject,   // Bad cyclic check sequence
  input  wire logic       cnt_load,     // Counters loaded alike
  input  wire logic       sev_bad,      // Invalid check pattern made
  input  wire logic       sev_run,      // Check-pattern test active
  input  wire logic       par_bad,      // Bad parity forced
  input  wire logic       par_run,      // Parity test active
  input  wire logic       rf_run,       // Register file test active
  input  wire logic [3:0] mod_addr,     // io_module addressed
  input  wire logic       mod_xfer,     // Transfer on the bus
  input  wire logic       mod_badchk,   // Transfer with bad check bits
  output logic            rx_addr_hit,
  output logic            crc_err,
  output logic      [2:0] cnt_carry,
  output logic            sev_err,
  output logic            par_err,
  output logic            rf_err,
  output logic            mod_reply
);
  logic sel_mod;                        // Faulty module is addressed
  // Detector answers; each fault breaks one detector only
  always_comb
  begin
    sel_mod     = (mod_addr == 4'h5);
    rx_addr_hit = (probe_addr == own_addr);
    crc_err     = crc_inject & (fault != 4'h1);
    cnt_carry   = cnt_load ? ((fault == 4'h2) ? 3'h3 : 3'h7)
                           : 3'h0;
    sev_err     = (fault == 4'h3) ? 1'b0 :
                  (fault == 4'h4) ? sev_run : (sev_run & sev_bad);
    // Fault 8: parity stuck at odd; fault 9: tree always flags
    par_err     = (fault == 4'h8) ? 1'b0 :
                  (fault == 4'h9) ? par_run : (par_run & par_bad);
    rf_err      = rf_run & (fault == 4'h5);
    // Bad-check transfers must be ignored by healthy modules
    mod_reply   = mod_xfer & ~mod_badchk;
    if (sel_mod && fault == 4'h6)
      mod_reply = mod_xfer;             // Answers bad check bits
    if (sel_mod && fault == 4'h7)
      mod_reply = 1'b0;                 // Module unpowered
  end
endmodule : sst_far

// ---- verif/sequencer_self_test_test.sv ----
// Testbench of the sequencer self-test engine with its far-side model.
// Assumes the register port answers reads exactly one cycle later.
`timescale 1ns/1ps
module sequencer_self_test_test;
  import sst_pkg::*;
  logic        clk_sys, rst_b, reg_wr, reg_rd, reg_rd_ack, busy;
  logic [3:0]  reg_addr, mod_addr;
  logic [15:0] reg_wdata, reg_rdata, rd_q;
  logic [4:0]  own_addr, probe_addr;
  logic [3:0]  fault;
  logic [2:0]  cnt_carry;
  logic        rx_addr_hit, crc_err, sev_err, par_err, rf_err, mod_reply;
  logic        crc_inject, cnt_load, sev_bad, sev_run, par_bad, par_run;
  logic        rf_run, rf_addr_mode, mod_xfer, mod_badchk, ack_q;
  int          err_total, checks, f;
  // Expected status per fault; fatal ones expect no answer
  logic [15:0] exp_w [10] = '{W_PASS, 16'h0000, 16'h0000, W_SEV_BAD,
                              W_SEV_GOOD, W_RF_FAIL, W_MOD_FAIL | 16'h0005,
                              W_MOD_FAIL | 16'h0005, W_PAR_STUCK,
                              W_PAR_TREE};
  sst_top #(.LIMIT_CYC(WAIT_CYC)) uut (
    .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rd_ack(reg_rd_ack), .own_addr(own_addr),
    .rx_addr_hit(rx_addr_hit), .crc_err(crc_err), .cnt_carry(cnt_carry),
    .sev_err(sev_err), .par_err(par_err), .rf_err(rf_err),
    .mod_reply(mod_reply), .probe_addr(probe_addr),
    .crc_inject(crc_inject), .cnt_load(cnt_load), .sev_bad(sev_bad),
    .sev_run(sev_run), .par_bad(par_bad), .par_run(par_run),
    .rf_run(rf_run), .rf_addr_mode(rf_addr_mode), .mod_addr(mod_addr),
    .mod_xfer(mod_xfer), .mod_badchk(mod_badchk), .busy(busy));
  sst_far far (
    .fault(fault), .own_addr(own_addr), .probe_addr(probe_addr),
    .crc_inject(crc_inject), .cnt_load(cnt_load), .sev_bad(sev_bad),
    .sev_run(sev_run), .par_bad(par_bad), .par_run(par_run),
    .rf_run(rf_run), .mod_addr(mod_addr), .mod_xfer(mod_xfer),
    .mod_badchk(mod_badchk), .rx_addr_hit(rx_addr_hit),
    .crc_err(crc_err), .cnt_carry(cnt_carry), .sev_err(sev_err),
    .par_err(par_err), .rf_err(rf_err), .mod_reply(mod_reply));
  // 25 MHz system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // Verdict and end of run, shared by the tests and the watchdog
  task automatic end_sim();
    if (err_total == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim
  // Compare one value and count it
  task automatic chk(input string name, input logic [15:0] exp,
                     input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", name, exp, got);
      err_total++;
    end
  endtask : chk
  // One-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask : wr
  // One-cycle read strobe; answer taken in the following cycle only
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1;
    rd_q  = reg_rdata;
    ack_q = reg_rd_ack;
  endtask : rd
  // Reset also stands for a power cycle of the unit
  task automatic do_reset();
    @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask : do_reset
  // Start a run, then poll busy under a bound before reading status
  task automatic run(input logic [3:0] fs);
    int n;
    fault <= fs;
    wr(OFF_CTRL, 16'h0001);
    rd(OFF_CTRL);
    chk("busy", 16'h0001, rd_q & 16'h0001);
    n = 0;
    while (rd_q[CTRL_BUSY] !== 1'b0 && n < 2000)
    begin
      rd(OFF_CTRL);
      n++;
    end
    chk("done", 16'h0000, {15'h0, rd_q[CTRL_BUSY]});
    rd(OFF_STAT);
  endtask : run
  // Watchdog on the whole run
  initial
  begin
    #(40 * 60000);
    err_total++;
    end_sim();
  end
  // Main sequence
  initial
  begin
    rst_b = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 4'h0;
    reg_wdata = 16'h0000; own_addr = 5'h13; fault = 3'h0;
    err_total = 0; checks = 0;
    do_reset();
    rd(OFF_STAT);
    chk("stat_rst", STAT_RST, rd_q);
    rd(4'h8);
    chk("unmapped", 16'h0000, rd_q);
    chk("unm_ack", 16'h0001, {15'h0, ack_q});
    // Healthy and faulty runs, each from a fresh power cycle
    for (f = 0; f < 10; f++)
    begin
      do_reset();
      run(f[3:0]);
      chk("status", exp_w[f], rd_q);
      chk("ack", (f == 1 || f == 2) ? 16'h0 : 16'h1,
          {15'h0, ack_q});
      if (f == 0)
        chk("pass_bit", 16'h0001, {15'h0, rd_q[PASS_BIT]});
    end
    // Repeat without power cycle, unpowered module stays faulty
    run(4'h7);
    chk("repeat", (W_MOD_FAIL | 16'h0005) & ~W_REPEAT_CLR, rd_q);
    // Held result: a non-start control write changes nothing
    do_reset();
    run(4'h0);
    wr(OFF_CTRL, 16'h0002);
    wr(OFF_STAT, 16'h0000);
    rd(OFF_CTRL);
    chk("idle", 16'h0000, rd_q & 16'h0001);
    // Host wait after the command before the result is fetched
    repeat (WAIT_CYC) @(posedge clk_sys);
    rd(OFF_STAT);
    chk("held", W_PASS, rd_q);
    end_sim();
  end
endmodule : sequencer_self_test_test
